// ---- core/ccc_defines.vh ----
// Constants for the three-PLL clock configuration control block
`ifndef CCC_DEFINES_VH
`define CCC_DEFINES_VH

// ----------------------------------------------------------------
// Register byte addresses
// ----------------------------------------------------------------
`define CCC_ADDR_CTRL   8'h00
`define CCC_ADDR_PLL2   8'h04
`define CCC_ADDR_PLL3   8'h08
`define CCC_ADDR_DIVAB  8'h0c
`define CCC_ADDR_DIVCDE 8'h10
`define CCC_ADDR_SRC    8'h14
`define CCC_ADDR_CAP    8'h18
`define CCC_ADDR_SUSP   8'h1c
`define CCC_ADDR_STAT   8'h20
`define CCC_ADDR_TBL    8'h40
`define CCC_TBL_HI      3'h7

// ----------------------------------------------------------------
// Writable bit masks and reset values
// ----------------------------------------------------------------
`define CCC_MASK_CTRL   32'h0000_01ff
`define CCC_MASK_PLL    32'h0007_ffff
`define CCC_MASK_DIVAB  32'h7f7f_7f7f
`define CCC_MASK_DIVCDE 32'h0003_7f7f
`define CCC_MASK_SRC    32'h0000_7777
`define CCC_MASK_CAP    32'h0000_003f
`define CCC_MASK_SUSP   32'h0000_01ff
`define CCC_MASK_TBL    32'h0107_ffff
`define CCC_RST_CTRL    32'h0000_0001
`define CCC_RST_ZERO    32'h0000_0000

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define CCC_F_SHUTDOWN_FUNCTION_SELECT     0
`define CCC_F_PLLEN     3:1
`define CCC_F_OUTEN     8:4
`define CCC_F_Q         7:0
`define CCC_F_FB        18:8
`define CCC_F_DIVIDER_BANK_SELECT    24
`define CCC_F_DIVA0     6:0
`define CCC_F_DIVA1     14:8
`define CCC_F_DIVB0     22:16
`define CCC_F_DIVB1     30:24
`define CCC_F_DIVC      6:0
`define CCC_F_DIVD      14:8
`define CCC_F_DIVE      17:16
`define CCC_F_CAP       5:0
`define CCC_F_SUSPLL    2:0
`define CCC_F_SUSOUT    7:3
`define CCC_F_SUSEN     8

// ----------------------------------------------------------------
// Source select codes and fixed values
// ----------------------------------------------------------------
`define CCC_SRC_REF     3'h0
`define CCC_SRC_RSVD    3'h1
`define CCC_DIV_OFF     7'h00
`define CCC_DIVE_OFF    2'h0
`define CCC_DIVE_BY4    2'h1
`define CCC_STRB_ALL    4'hf

`endif

// ---- core/ccc_clock_config.v ----
// Configuration and control logic of a three-PLL clock generator
`timescale 1ns/1ps
`default_nettype none
`include "ccc_defines.vh"

module ccc_clock_config #(
    parameter [0:0] DIFF_VARIANT = 1'b0
) (
    input  wire        clk_sys,
    input  wire        arst_n,
    input  wire [7:0]  paddr,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [31:0] pwdata,
    input  wire [3:0]  pstrb,
    output reg  [31:0] prdata,
    output reg         pready,
    output reg         pslverr,
    input  wire        serialDataPin,
    input  wire        serialClockPin,
    input  wire        selectOrSuspendInput,
    input  wire        shutdownOePin,
    output reg  [23:0] pllRefDiv,
    output reg  [32:0] pllFbDiv,
    output reg  [2:0]  pllRun,
    output reg         oscRun,
    output reg  [27:0] outDiv,
    output reg  [11:0] outputSourceSelect,
    output reg  [3:0]  outInvert,
    output reg  [1:0]  clockEDiv,
    output reg  [4:0]  outEnable,
    output reg  [5:0]  loadCapacitanceCode,
    output reg         dFromE
);

    // ------------------------------------------------------------
    // Reset and pin synchronisers
    // ------------------------------------------------------------
    reg        rstMeta_reg;
    reg        rstSync_reg;
    reg  [3:0] pinMeta_reg;
    reg  [3:0] pinSync_reg;
    wire       rst_n = rstSync_reg;

    always @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            rstMeta_reg <= 1'b0;
            rstSync_reg <= 1'b0;
        end else begin
            rstMeta_reg <= 1'b1;
            rstSync_reg <= rstMeta_reg;
        end
    end

    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            pinMeta_reg <= 4'h0;
            pinSync_reg <= 4'h0;
        end else begin
            pinMeta_reg <= {shutdownOePin, selectOrSuspendInput, serialClockPin, serialDataPin};
            pinSync_reg <= pinMeta_reg;
        end
    end

    wire dataSync  = pinSync_reg[0];
    wire clkSync   = pinSync_reg[1];
    wire selSync   = pinSync_reg[2];
    wire shutSync  = pinSync_reg[3];

    // ------------------------------------------------------------
    // Configuration registers
    // ------------------------------------------------------------
    reg  [31:0] ctrl_reg;
    reg  [31:0] pll2_reg;
    reg  [31:0] pll3_reg;
    reg  [31:0] divAb_reg;
    reg  [31:0] divCde_reg;
    reg  [31:0] src_reg;
    reg  [31:0] cap_reg;
    reg  [31:0] susp_reg;
    reg  [31:0] tbl_reg [0:7];

    // Byte-lane merge, each lane lands on its own write
    function [31:0] mergeBytes;
        input [31:0] oldVal;
        input [31:0] newVal;
        input [3:0]  strb;
        input [31:0] mask;
        integer      i;
        begin
            mergeBytes = oldVal;
            for (i = 0; i < 4; i = i + 1) begin
                if (strb[i]) begin
                    mergeBytes[i*8 +: 8] = newVal[i*8 +: 8];
                end
            end
            mergeBytes = mergeBytes & mask;
        end
    endfunction

    wire       setupPhase = psel & ~penable;
    wire       wrTake     = psel & penable & pready & pwrite;
    wire       tblHit     = (paddr[7:5] == `CCC_ADDR_TBL >> 5) && (paddr[1:0] == 2'b00);
    wire [2:0] tblIdx     = paddr[4:2];

    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_reg   <= `CCC_RST_CTRL;
            pll2_reg   <= `CCC_RST_ZERO;
            pll3_reg   <= `CCC_RST_ZERO;
            divAb_reg  <= `CCC_RST_ZERO;
            divCde_reg <= `CCC_RST_ZERO;
            src_reg    <= `CCC_RST_ZERO;
            cap_reg    <= `CCC_RST_ZERO;
            susp_reg   <= `CCC_RST_ZERO;
        end else if (wrTake) begin
            case (paddr)
                `CCC_ADDR_CTRL:   ctrl_reg   <= mergeBytes(ctrl_reg, pwdata, pstrb, `CCC_MASK_CTRL);
                `CCC_ADDR_PLL2:   pll2_reg   <= mergeBytes(pll2_reg, pwdata, pstrb, `CCC_MASK_PLL);
                `CCC_ADDR_PLL3:   pll3_reg   <= mergeBytes(pll3_reg, pwdata, pstrb, `CCC_MASK_PLL);
                `CCC_ADDR_DIVAB:  divAb_reg  <= mergeBytes(divAb_reg, pwdata, pstrb, `CCC_MASK_DIVAB);
                `CCC_ADDR_DIVCDE: divCde_reg <= mergeBytes(divCde_reg, pwdata, pstrb, `CCC_MASK_DIVCDE);
                `CCC_ADDR_SRC:    src_reg    <= mergeBytes(src_reg, pwdata, pstrb, `CCC_MASK_SRC);
                `CCC_ADDR_CAP:    cap_reg    <= mergeBytes(cap_reg, pwdata, pstrb, `CCC_MASK_CAP);
                `CCC_ADDR_SUSP:   susp_reg   <= mergeBytes(susp_reg, pwdata, pstrb, `CCC_MASK_SUSP);
                default: begin
                end
            endcase
        end
    end

    // Eight-row setting table for PLL1 and the A/B bank select
    genvar row;
    generate
        for (row = 0; row < 8; row = row + 1) begin : gTbl
            always @(posedge clk_sys or negedge rst_n) begin
                if (!rst_n) begin
                    tbl_reg[row] <= `CCC_RST_ZERO;
                end else if (wrTake && tblHit && tblIdx == row) begin
                    tbl_reg[row] <= mergeBytes(tbl_reg[row], pwdata, pstrb, `CCC_MASK_TBL);
                end
            end
        end
    endgenerate

    // ------------------------------------------------------------
    // Straps, shutdown and suspend
    // ------------------------------------------------------------
    reg  [1:0] strap_reg;
    reg        strapDone_reg;
    reg        shutPrev_reg;
    reg  [2:0] rowSel_reg;
    reg  [1:0] pinFill_reg;

    wire shutdown_function_select      = ctrl_reg[`CCC_F_SHUTDOWN_FUNCTION_SELECT];
    wire pinLow     = ~shutSync;
    wire shutActive = shutdown_function_select & pinLow;
    wire susEn      = susp_reg[`CCC_F_SUSEN];
    wire susActive  = susEn & ~selSync;
    wire selBit     = susEn ? 1'b0 : selSync;
    // Strap capture window: first settled cycle or shutdown release
    wire strapWin   = pinFill_reg[1] & (~strapDone_reg | (shutPrev_reg & ~shutActive));

    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            strap_reg     <= 2'h0;
            strapDone_reg <= 1'b0;
            shutPrev_reg  <= 1'b0;
            rowSel_reg    <= 3'h0;
            pinFill_reg   <= 2'h0;
        end else begin
            // Straps wait until both synchroniser stages hold pin levels
            pinFill_reg  <= {pinFill_reg[0], 1'b1};
            shutPrev_reg <= shutActive;
            if (strapWin) begin
                strap_reg     <= {clkSync, dataSync};
                strapDone_reg <= 1'b1;
            end
            rowSel_reg <= {selBit, strap_reg};
        end
    end

    // ------------------------------------------------------------
    // Effective settings
    // ------------------------------------------------------------
    wire [31:0] rowWord = tbl_reg[rowSel_reg];
    wire        bankSel = rowWord[`CCC_F_DIVIDER_BANK_SELECT];
    wire [2:0]  pllEn   = ctrl_reg[`CCC_F_PLLEN];
    wire [4:0]  outEn   = ctrl_reg[`CCC_F_OUTEN];
    wire [2:0]  susPll  = susp_reg[`CCC_F_SUSPLL];
    wire [4:0]  susOut  = susp_reg[`CCC_F_SUSOUT];

    reg  [2:0]  pllRun_next;
    reg  [27:0] outDiv_next;
    reg  [1:0]  clockEDiv_next;

    always @* begin
        // PLL runs only when enabled, not suspended and not shut down
        pllRun_next = pllEn & ~({3{susActive}} & susPll) & {3{~shutActive}};
        // Whole word switches in one cycle from one registered row
        outDiv_next = { divCde_reg[`CCC_F_DIVD],
                        divCde_reg[`CCC_F_DIVC],
                        bankSel ? divAb_reg[`CCC_F_DIVB1] : divAb_reg[`CCC_F_DIVB0],
                        bankSel ? divAb_reg[`CCC_F_DIVA1] : divAb_reg[`CCC_F_DIVA0] };
        clockEDiv_next = DIFF_VARIANT ? `CCC_DIVE_BY4 : divCde_reg[`CCC_F_DIVE];
    end

    // ------------------------------------------------------------
    // Per-output source liveness and enable
    // ------------------------------------------------------------
    genvar ch;
    wire [3:0]  srcOk;
    wire [3:0]  divOn;
    wire [11:0] srcCode;
    wire [3:0]  srcPhase;
    generate
        for (ch = 0; ch < 4; ch = ch + 1) begin : gOut
            wire [2:0] code = src_reg[ch*4 +: 3];
            wire [1:0] pIdx = code[2:1];
            assign srcCode[ch*3 +: 3] = code;
            assign srcPhase[ch]       = code[0];
            // Reserved code counts as no source; dead PLL kills its outputs
            assign srcOk[ch] = (code == `CCC_SRC_REF) ? 1'b1 :
                               (code == `CCC_SRC_RSVD) ? 1'b0 :
                               pllRun_next[pIdx - 2'd1];
            assign divOn[ch] = (outDiv_next[ch*7 +: 7] != `CCC_DIV_OFF);
        end
    endgenerate

    wire       triAll  = pinLow;
    wire [4:0] susMask = {5{susActive}} & susOut;
    wire       eLive   = pllRun_next[0] & (clockEDiv_next != `CCC_DIVE_OFF);
    wire       dLive   = DIFF_VARIANT ? eLive : (srcOk[3] & divOn[3]);
    wire [4:0] liveAll = {eLive, dLive, srcOk[2:0] & divOn[2:0]};
    wire [4:0] oeNext  = liveAll & outEn & ~susMask & {5{~triAll}};

    // ------------------------------------------------------------
    // Output registers
    // ------------------------------------------------------------
    // All outputs straight from flip-flops
    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            pllRefDiv           <= 24'h000000;
            pllFbDiv            <= 33'h000000000;
            pllRun              <= 3'h0;
            oscRun              <= 1'b0;
            outDiv              <= 28'h0000000;
            outputSourceSelect  <= 12'h000;
            outInvert           <= 4'h0;
            clockEDiv           <= 2'h0;
            outEnable           <= 5'h00;
            loadCapacitanceCode <= 6'h00;
            dFromE              <= 1'b0;
        end else begin
            pllRefDiv <= { pll3_reg[`CCC_F_Q], pll2_reg[`CCC_F_Q], rowWord[`CCC_F_Q] };
            pllFbDiv  <= { pll3_reg[`CCC_F_FB], pll2_reg[`CCC_F_FB], rowWord[`CCC_F_FB] };
            pllRun    <= pllRun_next;
            oscRun    <= ~shutActive;
            outDiv    <= outDiv_next;
            outputSourceSelect <= srcCode;
            outInvert <= srcPhase;
            clockEDiv <= clockEDiv_next;
            outEnable <= oeNext;
            loadCapacitanceCode <= cap_reg[`CCC_F_CAP];
            dFromE    <= DIFF_VARIANT;
        end
    end

    // ------------------------------------------------------------
    // APB slave answer
    // ------------------------------------------------------------
    reg  [31:0] rdMux;
    reg         addrOk;

    always @* begin
        addrOk = 1'b1;
        rdMux  = `CCC_RST_ZERO;
        case (paddr)
            `CCC_ADDR_CTRL:   rdMux = ctrl_reg;
            `CCC_ADDR_PLL2:   rdMux = pll2_reg;
            `CCC_ADDR_PLL3:   rdMux = pll3_reg;
            `CCC_ADDR_DIVAB:  rdMux = divAb_reg;
            `CCC_ADDR_DIVCDE: rdMux = divCde_reg;
            `CCC_ADDR_SRC:    rdMux = src_reg;
            `CCC_ADDR_CAP:    rdMux = cap_reg;
            `CCC_ADDR_SUSP:   rdMux = susp_reg;
            `CCC_ADDR_STAT:   rdMux = { 17'h00000, outEnable, pllRun, susActive,
                                        shutActive, rowSel_reg, strap_reg };
            default: begin
                if (tblHit) begin
                    rdMux = tbl_reg[tblIdx];
                end else begin
                    addrOk = 1'b0;
                end
            end
        endcase
    end

    // Answer one cycle after setup, no wait states
    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= `CCC_RST_ZERO;
        end else begin
            pready  <= setupPhase;
            pslverr <= setupPhase & ~addrOk;
            if (setupPhase && !pwrite) begin
                prdata <= rdMux;
            end
        end
    end

endmodule // ccc_clock_config

`default_nettype wire

// ---- testbench/ccc_clock_config_checker.sv ----
// Concurrent checks on the ports of the clock configuration block
`timescale 1ns/1ps
`default_nettype none
module ccc_clock_config_checker (
    input wire logic        clk_sys,
    input wire logic        arst_n,
    input wire logic [7:0]  paddr,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        shutdownOePin,
    input wire logic [23:0] pllRefDiv,
    input wire logic [2:0]  pllRun,
    input wire logic        oscRun,
    input wire logic [27:0] outDiv,
    input wire logic [11:0] outputSourceSelect,
    input wire logic [3:0]  outInvert,
    input wire logic [4:0]  outEnable,
    input wire logic [5:0]  loadCapacitanceCode
);
    logic [2:0] lowCnt;
    logic       wrDone;
    logic       wrPll2;
    logic       wrCap;

    assign wrDone = psel && penable && pready && pwrite;
    assign wrPll2 = wrDone && paddr == 8'h04;
    assign wrCap  = wrDone && paddr == 8'h18;

    // Cycles the shutdown pin has been low
    always @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            lowCnt <= 3'h0;
        end else if (shutdownOePin) begin
            lowCnt <= 3'h0;
        end else if (lowCnt != 3'h7) begin
            lowCnt <= lowCnt + 3'h1;
        end
    end

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!arst_n);

    // ----------------------------------------------------------------
    // Properties
    // ----------------------------------------------------------------
    chk_ready_after_setup: assert property (psel && !penable |=> pready)
        else $error("no ready after setup");
    chk_ready_one_cycle: assert property (pready |=> !pready)
        else $error("ready longer than one cycle");
    chk_ready_in_access: assert property (pready |-> psel && penable)
        else $error("ready outside access");
    chk_err_with_ready: assert property (pslverr |-> pready)
        else $error("error without ready");
    chk_unmapped_error: assert property (psel && !penable && paddr == 8'h30 |=> pslverr)
        else $error("unmapped address accepted");
    chk_pll2_cause: assert property ($changed(pllRefDiv[15:8]) |-> $past(wrPll2, 2))
        else $error("pll2 divider changed without write");
    chk_cap_cause: assert property (!$past(wrCap, 2) |-> $stable(loadCapacitanceCode))
        else $error("load code changed without write");
    chk_pin_tristate: assert property (lowCnt == 3'h7 |-> outEnable == 5'h00)
        else $error("outputs driven with pin low");
    chk_osc_stop_pll: assert property (!oscRun |-> pllRun == 3'h0)
        else $error("pll runs with oscillator stopped");
    chk_div_zero_off: assert property (outDiv[20:14] == 7'h00 |-> !outEnable[2])
        else $error("output c driven with divider zero");
    chk_invert_phase: assert property (outInvert == {outputSourceSelect[9],
        outputSourceSelect[6], outputSourceSelect[3], outputSourceSelect[0]})
        else $error("invert does not follow source code");

    cover property (wrDone && paddr == 8'h40);
    cover property (pslverr);
    cover property (!oscRun);
    cover property (outEnable == 5'h08);
endmodule // ccc_clock_config_checker
`default_nettype wire

// ---- testbench/ccc_host_model.sv ----
// Host controller model that reads and writes configuration words
`timescale 1ns/1ps
`default_nettype none
module ccc_host_model (
    input  wire logic        clk_sys,
    output var  logic [7:0]  paddr,
    output var  logic        psel,
    output var  logic        penable,
    output var  logic        pwrite,
    output var  logic [31:0] pwdata,
    output var  logic [3:0]  pstrb,
    input  wire logic [31:0] prdata,
    input  wire logic        pready,
    input  wire logic        pslverr
);
    initial begin
        paddr = 8'h00;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        pwdata = 32'h0000_0000;
        pstrb = 4'h0;
    end

    // ----------------------------------------------------------------
    // Bus transfer
    // ----------------------------------------------------------------
    task automatic xfer(input logic wr, input logic [7:0] addr, input logic [31:0] data,
                        input logic [3:0] strb, output logic [31:0] rdata, output logic err);
        @(posedge clk_sys);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= addr;
        pwdata <= data;
        pstrb <= strb;
        @(posedge clk_sys);
        penable <= 1'b1;
        do begin
            @(posedge clk_sys);
        end while (pready !== 1'b1);
        rdata = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        pwdata <= ~data;
    endtask

    // All three loops paused while the divider bytes change
    task automatic pll_update(input logic [7:0] addr, input logic [31:0] data,
                              input logic [3:0] strb, input logic [31:0] ctrl);
        logic [31:0] rd;
        logic        er;
        xfer(1'b1, 8'h00, ctrl & ~32'h0000_000e, 4'hf, rd, er);
        xfer(1'b1, addr, data, strb, rd, er);
        xfer(1'b1, 8'h00, ctrl, 4'hf, rd, er);
    endtask
endmodule // ccc_host_model
`default_nettype wire

// ---- testbench/ccc_clock_config_tb.sv ----
// Self-checking bench for the clock configuration block
`timescale 1ns/1ps
`default_nettype none
module ccc_clock_config_tb;
    logic        clk_sys, arst_n, psel, penable, pwrite, pready, pslverr, er;
    logic        serialDataPin, serialClockPin, selectOrSuspendInput, shutdownOePin;
    logic        oscRun, dFromE;
    logic [7:0]  paddr;
    logic [3:0]  pstrb, outInvert;
    logic [31:0] pwdata, prdata, rd;
    logic [23:0] pllRefDiv;
    logic [32:0] pllFbDiv;
    logic [2:0]  pllRun;
    logic [27:0] outDiv;
    logic [11:0] outputSourceSelect;
    logic [1:0]  clockEDiv;
    logic [4:0]  outEnable;
    logic [5:0]  loadCapacitanceCode;
    int          fails, samples_checked;

    ccc_clock_config #(.DIFF_VARIANT(1'b0)) ccc_clock_config_inst (.clk_sys, .arst_n,
        .paddr, .psel, .penable, .pwrite, .pwdata, .pstrb, .prdata, .pready, .pslverr,
        .serialDataPin, .serialClockPin, .selectOrSuspendInput, .shutdownOePin,
        .pllRefDiv, .pllFbDiv, .pllRun, .oscRun, .outDiv, .outputSourceSelect,
        .outInvert, .clockEDiv, .outEnable, .loadCapacitanceCode, .dFromE);
    ccc_host_model ccc_host_model_inst (.clk_sys, .paddr, .psel, .penable, .pwrite,
        .pwdata, .pstrb, .prdata, .pready, .pslverr);

    initial begin
        clk_sys = 1'b0;
        forever #20 clk_sys = ~clk_sys;
    end

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            fails++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        ccc_host_model_inst.xfer(1'b1, a, d, 4'hf, rd, er);
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
        ccc_host_model_inst.xfer(1'b0, a, 32'h0, 4'h0, rd, er);
        check(rd & m, e);
    endtask
    task automatic wait_clk(input int n);
        repeat (n) @(posedge clk_sys);
    endtask
    task automatic finish_test();
        $display("checks=%0d mismatches=%0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    initial begin
        repeat (5000) @(posedge clk_sys);
        fails++;
        finish_test();
    end

    // ----------------------------------------------------------------
    // Tests
    // ----------------------------------------------------------------
    initial begin
        fails = 0;
        samples_checked = 0;
        arst_n = 1'b0;
        serialDataPin = 1'b0;
        serialClockPin = 1'b1;
        selectOrSuspendInput = 1'b1;
        shutdownOePin = 1'b1;
        wait_clk(10);
        arst_n <= 1'b1;
        wait_clk(12);
        rd_chk(8'h00, 32'hffff_ffff, 32'h0000_0001);
        for (int a = 4; a < 32; a += 4) begin
            rd_chk(8'(a), 32'hffff_ffff, 32'h0);
        end
        rd_chk(8'h20, 32'h1f, 32'h1a);
        wr(8'h30, 32'hffff_ffff);
        check(32'(er), 32'h1);
        rd_chk(8'h30, 32'hffff_ffff, 32'h0);
        check(32'(er), 32'h1);
        $display("test reset_map done");

        wr(8'h00, 32'h0000_01ff);
        ccc_host_model_inst.pll_update(8'h04, 32'h0007_ffff, 4'h1, 32'h0000_01ff);
        wait_clk(2);
        check(32'(pllRefDiv[15:8]), 32'hff);
        check(32'(pllFbDiv[21:11]), 32'h0);
        ccc_host_model_inst.pll_update(8'h04, 32'h0000_3300, 4'h2, 32'h0000_01ff);
        wait_clk(2);
        check(32'(pllFbDiv[21:11]), 32'h33);
        check(32'(pllRefDiv[15:8]), 32'hff);
        ccc_host_model_inst.pll_update(8'h08, 32'hfff4_5a12, 4'hf, 32'h0000_01ff);
        rd_chk(8'h08, 32'hffff_ffff, 32'h0004_5a12);
        check(32'(pllRefDiv[23:16]), 32'h12);
        check(32'(pllFbDiv[32:22]), 32'h45a);
        $display("test pll_bytes done");

        serialDataPin <= 1'b1;
        serialClockPin <= 1'b0;
        for (int i = 0; i < 8; i++) begin
            wr(8'(8'h40 + i * 4), 32'hffff_ffff);
            rd_chk(8'(8'h40 + i * 4), 32'hffff_ffff, 32'h0107_ffff);
        end
        wr(8'h58, 32'h0000_0822);
        wr(8'h0c, 32'h0403_0201);
        wait_clk(2);
        check(32'(pllRefDiv[7:0]), 32'h22);
        check(32'(pllFbDiv[10:0]), 32'h8);
        check(32'(outDiv[13:0]), 32'h181);
        rd_chk(8'h20, 32'h1f, 32'h1a);
        serialDataPin <= 1'b0;
        serialClockPin <= 1'b1;
        wr(8'h48, 32'h0100_0411);
        selectOrSuspendInput <= 1'b0;
        for (int i = 0; i < 6; i++) begin
            @(negedge clk_sys);
            check(32'(pllRefDiv[7:0] == 8'h11), 32'(outDiv[6:0] == 7'h02));
        end
        check(32'(pllFbDiv[10:0]), 32'h4);
        check(32'(outDiv[13:0]), 32'h202);
        $display("test select_table done");

        for (int c = 0; c < 8; c++) begin
            wr(8'h14, 32'h0000_1111 * c);
            wait_clk(2);
            check(32'(outputSourceSelect), 32'h249 * c);
            check(32'(outInvert), (c % 2) ? 32'hf : 32'h0);
            if (c == 1) check(32'(outEnable[3:0]), 32'h0);
        end
        wr(8'h14, 32'h0);
        $display("test sources done");

        wr(8'h10, 32'h0002_0505);
        wait_clk(2);
        check(32'(outEnable), 32'h1f);
        check(32'(clockEDiv), 32'h2);
        check(32'(outDiv[27:14]), 32'h285);
        check(32'(dFromE), 32'h0);
        check(32'(pllRun), 32'h7);
        wr(8'h10, 32'h0002_0500);
        wr(8'h00, 32'h0000_01eb);
        wait_clk(2);
        check(32'(outEnable), 32'h1a);
        check(32'(pllRun), 32'h5);
        shutdownOePin <= 1'b0;
        wait_clk(6);
        check(32'(outEnable), 32'h0);
        check(32'({pllRun, oscRun}), 32'h0);
        wr(8'h18, 32'hffff_ffea);
        rd_chk(8'h18, 32'hffff_ffff, 32'h2a);
        check(32'(loadCapacitanceCode), 32'h2a);
        shutdownOePin <= 1'b1;
        wait_clk(12);
        check(32'(outEnable), 32'h1a);
        check(32'({pllRun, oscRun}), 32'hb);
        wr(8'h00, 32'h0000_01ea);
        shutdownOePin <= 1'b0;
        wait_clk(6);
        check(32'(outEnable), 32'h0);
        check(32'({pllRun, oscRun}), 32'hb);
        shutdownOePin <= 1'b1;
        selectOrSuspendInput <= 1'b1;
        wr(8'h1c, 32'h0000_0191);
        wait_clk(6);
        check(32'(outEnable), 32'h1a);
        selectOrSuspendInput <= 1'b0;
        wait_clk(6);
        check(32'(outEnable), 32'h08);
        check(32'(pllRun), 32'h4);
        $display("test power done");
        finish_test();
    end
endmodule // ccc_clock_config_tb

bind ccc_clock_config ccc_clock_config_checker ccc_clock_config_checker_inst (.clk_sys,
    .arst_n, .paddr, .psel, .penable, .pwrite, .pready, .pslverr, .shutdownOePin,
    .pllRefDiv, .pllRun, .oscRun, .outDiv, .outputSourceSelect, .outInvert, .outEnable,
    .loadCapacitanceCode);
`default_nettype wire
